// >>> logic/tmcap_edge_filter.v
`timescale 1ns/100ps
`include "tmcap_regs.vh"
// Capture pin sampler: a level counts only after three equal samples
module tmcap_edge_filter (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       smp_tick,
   input  wire       pin_in,
   input  wire [1:0] edge_mode,
   output reg        edge_pulse
);
   reg       level_reg;
   reg       sync_reg;
   reg [1:0] run_reg;
   wire      candidate;

   assign candidate = (sync_reg != level_reg);

   // Stable-level qualification on sampling ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg  <= 1'b0;
         sync_reg   <= 1'b0;
         run_reg    <= 2'h0;
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= 1'b0;
         if (smp_tick) begin
            sync_reg <= pin_in;
            if (!candidate) begin
               run_reg <= 2'h0;
            end else if (run_reg == `TMCAP_MIN_LEVEL - 1) begin
               run_reg   <= 2'h0;
               level_reg <= sync_reg;
               case (edge_mode)
                  `TMCAP_EDGE_RISE: edge_pulse <= sync_reg;
                  `TMCAP_EDGE_FALL: edge_pulse <= ~sync_reg;
                  `TMCAP_EDGE_BOTH: edge_pulse <= 1'b1;
                  default:          edge_pulse <= 1'b0;
               endcase
            end else begin
               run_reg <= run_reg + 2'h1;
            end
         end
      end
   end
endmodule // tmcap_edge_filter

// >>> logic/tmcap_regs.vh
`ifndef TMCAP_REGS_VH
`define TMCAP_REGS_VH
// Register byte offsets
`define TMCAP_CTRL_OFS      12'h000
`define TMCAP_PRESC_OFS     12'h004
`define TMCAP_CCCTRL_OFS    12'h008
`define TMCAP_EDGE_OFS      12'h00C
`define TMCAP_CMP0_OFS      12'h010
`define TMCAP_CMP1_OFS      12'h014
`define TMCAP_COUNT_OFS     12'h018
`define TMCAP_STAT_OFS      12'h01C
`define TMCAP_MASK_OFS      12'h020
`define TMCAP_SMPSEL_OFS    12'h024
// Control register fields
`define TMCAP_CTRL_CE_BIT   0
`define TMCAP_CTRL_SRC_BIT  1
// Capture/compare control fields
`define TMCAP_CC_CAP_BIT    0
`define TMCAP_CC_CLR_BIT    1
`define TMCAP_CC_CLR0_BIT   2
// Status / mask fields
`define TMCAP_ST_CMP0_BIT   0
`define TMCAP_ST_CMP1_BIT   1
`define TMCAP_ST_CAP_BIT    2
// Edge modes
`define TMCAP_EDGE_NONE     2'h0
`define TMCAP_EDGE_RISE     2'h1
`define TMCAP_EDGE_FALL     2'h2
`define TMCAP_EDGE_BOTH     2'h3
// Reset values
`define TMCAP_PRESC_RST     4'h0
`define TMCAP_CMP_RST       8'hFF
// Minimum stable level, in sampling clocks
`define TMCAP_MIN_LEVEL     3
`endif

// >>> logic/tmcap_timer.v
`timescale 1ns/100ps
`include "tmcap_regs.vh"
module tmcap_timer #(
   parameter CW = 8
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        capture_edge_pin,
   output reg         irq
);
   // Software-visible registers
   reg          count_enable_bit_reg;
   reg          cc_source_reg;
   reg [3:0]    prescaler_mode_reg;
   reg [2:0]    capture_compare_ctrl_reg;
   reg [1:0]    edge_mode_reg;
   reg [1:0]    sampling_clock_select_reg;
   reg [CW-1:0] compare_value_0_reg;
   reg [CW-1:0] capture_compare_value_reg;
   reg [CW-1:0] timer_count_reg;
   reg [2:0]    status_reg;
   reg [2:0]    mask_reg;
   // Internal state
   reg [10:0]   presc_reg;
   reg [7:0]    smp_div_reg;
   reg          clr_pend_reg;
   reg          irq_next;
   reg [31:0]   rdata_next;
   reg [2:0]    set_ev;
   reg          count_tick;
   reg          smp_tick;
   wire         cap_edge;
   wire         wr_acc;
   wire         rd_acc;
   wire         cap_mode;
   wire         wr_cmp0;
   wire         wr_cmp1;
   wire [CW-1:0] count_inc;
   wire         match0;
   wire         match1;

   // Divider tap for a prescaler code: 0 -> /8 up to 8 -> /2048
   function tap_hit;
      input [10:0] cnt;
      input [3:0]  sel;
      reg   [10:0] mask;
      begin
         mask    = (11'h008 << sel) - 11'h001;
         tap_hit = ((cnt & mask) == mask);
      end
   endfunction

   assign wr_acc   = psel & penable & pwrite;
   assign rd_acc   = psel & penable & ~pwrite;
   assign cap_mode = capture_compare_ctrl_reg[`TMCAP_CC_CAP_BIT];
   assign wr_cmp0  = wr_acc & (paddr == `TMCAP_CMP0_OFS);
   assign wr_cmp1  = wr_acc & (paddr == `TMCAP_CMP1_OFS) & ~cap_mode;
   assign count_inc = timer_count_reg + {{(CW-1){1'b0}}, 1'b1};

   // Compare only against the incremented value, never on a write
   // Increment-only match
   assign match0 = count_tick & ~wr_cmp0 &
                   (count_inc == compare_value_0_reg);
   assign match1 = count_tick & ~wr_cmp1 & ~cap_mode &
                   (count_inc == capture_compare_value_reg);

   // Prescaler and sampling-clock ticks, free running
   always @* begin
      count_tick = count_enable_bit_reg &
                   tap_hit(presc_reg, prescaler_mode_reg);
      case (sampling_clock_select_reg)
         2'h0:    smp_tick = 1'b1;
         2'h1:    smp_tick = (smp_div_reg[5:0] == 6'h3F);
         2'h2:    smp_tick = (smp_div_reg[6:0] == 7'h7F);
         default: smp_tick = (smp_div_reg == 8'hFF);
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg   <= 11'h000;
         smp_div_reg <= 8'h00;
      end else begin
         presc_reg   <= presc_reg + 11'h001;
         smp_div_reg <= smp_div_reg + 8'h01;
      end
   end

   tmcap_edge_filter u_filter (
      .pclk       (pclk),
      .presetn    (presetn),
      .smp_tick   (smp_tick),
      .pin_in     (capture_edge_pin),
      .edge_mode  (edge_mode_reg),
      .edge_pulse (cap_edge)
   );

   // Event collection for the status register
   always @* begin
      set_ev = 3'h0;
      set_ev[`TMCAP_ST_CMP0_BIT] = match0;
      set_ev[`TMCAP_ST_CMP1_BIT] = match1;
      set_ev[`TMCAP_ST_CAP_BIT]  = cap_edge & cap_mode;
   end

   // Counter, capture and control registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_enable_bit_reg      <= 1'b0;
         cc_source_reg             <= 1'b0;
         prescaler_mode_reg        <= `TMCAP_PRESC_RST;
         capture_compare_ctrl_reg  <= 3'h0;
         edge_mode_reg             <= `TMCAP_EDGE_NONE;
         sampling_clock_select_reg <= 2'h0;
         compare_value_0_reg       <= `TMCAP_CMP_RST;
         capture_compare_value_reg <= `TMCAP_CMP_RST;
         timer_count_reg           <= {CW{1'b0}};
         clr_pend_reg              <= 1'b0;
      end else begin
         // Count path; start waits for the next prescaler tap
         // First tap latency
         if (!count_enable_bit_reg) begin
            timer_count_reg <= {CW{1'b0}};
            clr_pend_reg    <= 1'b0;
         end else if (count_tick) begin
            // Clear on match
            // Count rests on the compare value one tick: n+1 ticks
            if (clr_pend_reg || (!cap_mode &&
                capture_compare_ctrl_reg[`TMCAP_CC_CLR_BIT] &&
                timer_count_reg == capture_compare_value_reg)
                || (capture_compare_ctrl_reg[`TMCAP_CC_CLR0_BIT] &&
                    timer_count_reg == compare_value_0_reg)) begin
               timer_count_reg <= {CW{1'b0}};
               clr_pend_reg    <= 1'b0;
            end else begin
               timer_count_reg <= count_inc;
            end
         end
         if (cap_edge && cap_mode) begin
            capture_compare_value_reg <= timer_count_reg;
            if (capture_compare_ctrl_reg[`TMCAP_CC_CLR_BIT])
               clr_pend_reg <= count_enable_bit_reg;
         end
         if (wr_acc) begin
            case (paddr)
               `TMCAP_CTRL_OFS: begin
                  count_enable_bit_reg <= pwdata[`TMCAP_CTRL_CE_BIT];
                  if (!count_enable_bit_reg)
                     timer_count_reg <= {CW{1'b0}};
                  cc_source_reg <= pwdata[`TMCAP_CTRL_SRC_BIT];
               end
               `TMCAP_PRESC_OFS:  prescaler_mode_reg <= pwdata[3:0];
               `TMCAP_CCCTRL_OFS:
                  capture_compare_ctrl_reg <= pwdata[2:0];
               `TMCAP_EDGE_OFS:   edge_mode_reg <= pwdata[1:0];
               `TMCAP_SMPSEL_OFS:
                  sampling_clock_select_reg <= pwdata[1:0];
               `TMCAP_CMP0_OFS:   compare_value_0_reg <= pwdata[CW-1:0];
               `TMCAP_CMP1_OFS: begin
                  if (!cap_mode)
                     capture_compare_value_reg <= pwdata[CW-1:0];
               end
               default: ;
            endcase
         end
      end
   end

   // Sticky status, set wins over write-one-to-clear
   // Sticky request flags
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 3'h0;
         mask_reg   <= 3'h0;
         irq        <= 1'b0;
      end else begin
         if (wr_acc && paddr == `TMCAP_STAT_OFS)
            status_reg <= (status_reg & ~pwdata[2:0]) | set_ev;
         else
            status_reg <= status_reg | set_ev;
         if (wr_acc && paddr == `TMCAP_MASK_OFS)
            mask_reg <= pwdata[2:0];
         irq <= irq_next;
      end
   end

   always @* begin
      irq_next = |(status_reg & mask_reg);
   end

   // Read mux
   always @* begin
      rdata_next = 32'h00000000;
      case (paddr)
         `TMCAP_CTRL_OFS:
            rdata_next[1:0] = {cc_source_reg, count_enable_bit_reg};
         `TMCAP_PRESC_OFS:  rdata_next[3:0] = prescaler_mode_reg;
         `TMCAP_CCCTRL_OFS: rdata_next[2:0] = capture_compare_ctrl_reg;
         `TMCAP_EDGE_OFS:   rdata_next[1:0] = edge_mode_reg;
         `TMCAP_SMPSEL_OFS: rdata_next[1:0] = sampling_clock_select_reg;
         `TMCAP_CMP0_OFS:   rdata_next[CW-1:0] = compare_value_0_reg;
         `TMCAP_CMP1_OFS:   rdata_next[CW-1:0] = capture_compare_value_reg;
         `TMCAP_COUNT_OFS:  rdata_next[CW-1:0] = timer_count_reg;
         `TMCAP_STAT_OFS:   rdata_next[2:0] = status_reg;
         `TMCAP_MASK_OFS:   rdata_next[2:0] = mask_reg;
         default:           rdata_next = 32'h00000000;
      endcase
   end

   // APB answer: zero wait states, error on unmapped address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `TMCAP_SMPSEL_OFS ||
                    paddr[1:0] != 2'h0);
         if (psel && !penable)
            prdata <= rdata_next;
      end
   end
endmodule // tmcap_timer

// >>> testbench/tb.sv
`timescale 1ns/100ps
`include "tmcap_regs.vh"
`define CHK(nm, e, s) begin tests_run = tests_run + 1; \
   if ((s) !== (e)) begin err_total = err_total + 1; \
   $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb;
   reg         pclk, presetn, psel, penable, pwrite, re;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd, c0;
   wire [31:0] prdata;
   wire        pready, pslverr, irq, pin;
   integer     err_total, tests_run, cyc, t0, m, n;
   tmcap_timer tmcap_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_edge_pin(pin), .irq(irq));
   tmcap_pulse_src tmcap_pulse_src_i (.pclk(pclk), .pin(pin));
   // Clock and cycle count
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task results;
      begin
         $display("checks %0d errors %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // Hang guard shared by the apb and wirq waits
   task bail;
      begin
         err_total = err_total + 1;
         results;
      end
   endtask
   // One APB transfer, held until pready
   task apb(input reg w, input [11:0] a, input [31:0] d);
      begin
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 20);
         if (pready !== 1'b1)
            bail;
         rd = prdata;
         re = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // Bounded wait for an irq level
   task wirq(input reg v, input integer lim);
      begin
         n = 0;
         while (irq !== v && n < lim) begin
            @(posedge pclk);
            n = n + 1;
         end
         if (irq !== v)
            bail;
      end
   endtask
   task t_reset;
      begin
         `CHK("irq", 1'b0, irq)
         apb(1'b0, `TMCAP_CMP0_OFS, 32'h0);
         `CHK("cmp0", 32'h000000FF, rd)
         apb(1'b0, `TMCAP_COUNT_OFS, 32'h0);
         `CHK("count", 32'h0, rd)
         apb(1'b0, 12'h028, 32'h0);
         `CHK("slverr", 1'b1, re)
         `CHK("rdata", 32'h0, rd)
         apb(1'b1, 12'h013, 32'h5);
         `CHK("slverr", 1'b1, re)
      end
   endtask
   task t_interval;
      begin
         apb(1'b1, `TMCAP_CMP1_OFS, 32'h3);
         apb(1'b1, `TMCAP_CCCTRL_OFS, 32'h2);
         apb(1'b1, `TMCAP_MASK_OFS, 32'h2);
         apb(1'b1, `TMCAP_CTRL_OFS, 32'h1);
         wirq(1'b1, 100);
         t0 = cyc;
         apb(1'b1, `TMCAP_STAT_OFS, 32'h2);
         wirq(1'b0, 10);
         wirq(1'b1, 100);
         // Four ticks of pclk/8 between matches
         `CHK("period", 32'h20, cyc - t0)
         apb(1'b0, `TMCAP_STAT_OFS, 32'h0);
         `CHK("stat", 32'h2, rd)
         apb(1'b1, `TMCAP_CMP0_OFS, 32'h0);
         apb(1'b1, `TMCAP_STAT_OFS, 32'h7);
         repeat (80) @(posedge pclk);
         apb(1'b0, `TMCAP_STAT_OFS, 32'h0);
         `CHK("clear", 32'h2, rd)
         apb(1'b1, `TMCAP_MASK_OFS, 32'h0);
         apb(1'b1, `TMCAP_CTRL_OFS, 32'h0);
         apb(1'b1, `TMCAP_STAT_OFS, 32'h3);
         apb(1'b0, `TMCAP_COUNT_OFS, 32'h0);
         `CHK("count", 32'h0, rd)
         `CHK("irq", 1'b0, irq)
      end
   endtask
   task t_capture;
      begin
         // Reconfigured while the counter is stopped
         apb(1'b1, `TMCAP_CCCTRL_OFS, 32'h1);
         apb(1'b1, `TMCAP_SMPSEL_OFS, 32'h0);
         apb(1'b1, `TMCAP_CTRL_OFS, 32'h1);
         for (m = 0; m < 4; m = m + 1) begin
            apb(1'b1, `TMCAP_EDGE_OFS, m);
            apb(1'b1, `TMCAP_STAT_OFS, 32'h7);
            tmcap_pulse_src_i.hold(1'b1, 12);
            apb(1'b0, `TMCAP_STAT_OFS, 32'h0);
            `CHK("rise", m[0], rd[2])
            apb(1'b1, `TMCAP_STAT_OFS, 32'h4);
            tmcap_pulse_src_i.hold(1'b0, 12);
            apb(1'b0, `TMCAP_STAT_OFS, 32'h0);
            `CHK("fall", m[1], rd[2])
         end
         apb(1'b1, `TMCAP_STAT_OFS, 32'h4);
         tmcap_pulse_src_i.hold(1'b1, 2);
         tmcap_pulse_src_i.hold(1'b0, 12);
         apb(1'b0, `TMCAP_STAT_OFS, 32'h0);
         `CHK("glitch", 1'b0, rd[2])
         // High level of exactly 80 pclk is ten counts
         t0 = cyc;
         tmcap_pulse_src_i.hold(1'b1, 40);
         apb(1'b0, `TMCAP_CMP1_OFS, 32'h0);
         c0 = rd;
         while (cyc - t0 < 80)
            @(posedge pclk);
         tmcap_pulse_src_i.hold(1'b0, 40);
         apb(1'b0, `TMCAP_CMP1_OFS, 32'h0);
         `CHK("width", 8'hA, rd[7:0] - c0[7:0])
      end
   endtask
   // Reset, then the scenarios
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      cyc = 0;
      err_total = 0;
      tests_run = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_interval;
      t_capture;
      results;
   end
endmodule // tb
bind tmcap_timer tmcap_props tmcap_props_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

// >>> testbench/tmcap_props.sv
`timescale 1ns/100ps
module tmcap_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Bus phases as the slave sees them
   sequence s_set; psel && !penable; endsequence
   sequence s_wr; pready && pwrite; endsequence
   property p_rdy; s_set |=> pready && penable; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready held");
   property p_cause; pready |-> psel && penable; endproperty
   a_cause: assert property (p_cause) else $error("pready stray");
   property p_err;
      s_set ##0 (paddr > 12'h024 || paddr[1:0] != 2'h0) |=> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("no pslverr");
   property p_ok;
      s_set ##0 (paddr <= 12'h024 && paddr[1:0] == 2'h0) |=> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("false pslverr");
   property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("refused read data");
   // Masking everything silences the line two edges on
   property p_mask0;
      s_wr ##0 (paddr == 12'h020 && pwdata == 32'h0) |=> ##1 !irq;
   endproperty
   a_mask0: assert property (p_mask0) else $error("irq not masked");
   // Flags are sticky, so the line only drops after a write
   property p_fall;
      $fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
   endproperty
   a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule // tmcap_props

// >>> testbench/tmcap_pulse_src.sv
`timescale 1ns/100ps
module tmcap_pulse_src (
   input  wire pclk,
   output reg  pin
);
   // Pin idles low
   initial pin = 1'b0;
   // Levels under three samples only on request
   task hold(input reg v, input integer n);
      begin
         pin <= v;
         repeat (n) @(posedge pclk);
      end
   endtask
endmodule // tmcap_pulse_src
